// ==== src/spf_core.sv ====
// Interrupt persistence filters, long wait and LED pulse sequencer.
`timescale 1ns/1ps
`include "spf_params.svh"

module spf_core #(
  parameter int unsigned TIME_BASE_CYCLES =
    `SPF_TIME_BASE_NS / `SPF_CLK_PERIOD_NS
) (
  // Clock and reset.
  input  wire logic                 i_clock,
  input  wire logic                 i_rst_b,
  // Register access and special-function commands.
  input  wire spf_pkg::spf_reg_req_t i_reg_req,
  input  wire logic                 i_sf_valid,
  input  wire logic [4:0]           i_sf_code,
  output logic [7:0]                o_reg_rdata,
  // Settings held in neighbouring registers.
  input  wire logic                 i_light_enable,
  input  wire logic                 i_prox_enable,
  input  wire logic                 i_wait_enable,
  input  wire logic                 i_prox_irq_mask,
  input  wire logic                 i_light_irq_mask,
  input  wire logic [7:0]           i_light_integration_setting,
  input  wire logic [7:0]           i_wait_period_setting,
  // Conversion results with their thresholds.
  input  wire spf_pkg::spf_result_t i_channel_zero_result,
  input  wire spf_pkg::spf_result_t i_prox_result,
  // Sequencer and interrupt outputs.
  output logic                      o_led_pulse,
  output logic                      o_light_cycle_end,
  output logic                      o_prox_cycle_end,
  output logic                      o_prox_irq_pending,
  output logic                      o_light_irq_pending,
  output logic                      o_int_out,
  output logic                      o_int_oe_b
);

  // Half of the LED pulse period is the on time.
  localparam logic [8:0] PULSE_LAST = 9'(`SPF_PULSE_CYCLES - 1);
  localparam logic [8:0] PULSE_HALF = 9'(`SPF_PULSE_CYCLES / 2);
  localparam logic [23:0] TICK_LAST = 24'(TIME_BASE_CYCLES - 1);

  // True when a result lies outside its threshold window.
  function automatic logic out_of_range(input spf_pkg::spf_result_t r);
    out_of_range = (r.result < r.low) || (r.result > r.high);
  endfunction

  // Number of consecutive out-of-range light results for a code.
  function automatic logic [5:0] light_required(input logic [3:0] code);
    if (code <= 4'h3) begin
      light_required = {2'b00, code};
    end else begin
      light_required = 6'(5 * ({2'b00, code} - 6'h03));
    end
  endfunction

  // Configuration registers.
  logic [7:0] persistence_filter_reg;  // Both persistence fields.
  logic       long_wait_multiplier;    // Stretches the wait phase.
  logic [7:0] led_pulse_count;         // Pulses per proximity cycle.
  logic [7:0] next_persistence_filter_reg;
  logic       next_long_wait_multiplier;
  logic [7:0] next_led_pulse_count;
  logic [7:0] next_reg_rdata;

  // Register writes and reads; read data is registered one cycle later.
  always_comb begin
    next_persistence_filter_reg = persistence_filter_reg;
    next_long_wait_multiplier   = long_wait_multiplier;
    next_led_pulse_count        = led_pulse_count;
    next_reg_rdata              = o_reg_rdata;
    if (i_reg_req.wr) begin
      case (i_reg_req.addr)
        `SPF_OFS_PERSIST: begin
          next_persistence_filter_reg = i_reg_req.wdata;
        end
        `SPF_OFS_WAIT_CFG: begin
          // Reserved bits are dropped so they always read as zero.
          next_long_wait_multiplier =
            i_reg_req.wdata[`SPF_LONG_WAIT_BIT];
        end
        `SPF_OFS_PULSE_CNT: begin
          next_led_pulse_count = i_reg_req.wdata;
        end
        default: begin
          // Other offsets belong to other blocks.
        end
      endcase
    end
    if (i_reg_req.rd) begin
      case (i_reg_req.addr)
        `SPF_OFS_PERSIST:   next_reg_rdata = persistence_filter_reg;
        `SPF_OFS_WAIT_CFG:  next_reg_rdata = {6'h00, long_wait_multiplier,
                                              1'b0};
        `SPF_OFS_PULSE_CNT: next_reg_rdata = led_pulse_count;
        default:            next_reg_rdata = 8'h00;
      endcase
    end
  end

  // Register state.
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      persistence_filter_reg <= `SPF_RST_PERSIST;
      long_wait_multiplier   <= `SPF_RST_LONG_WAIT;
      led_pulse_count        <= `SPF_RST_PULSE_CNT;
      o_reg_rdata            <= 8'h00;
    end else begin
      persistence_filter_reg <= next_persistence_filter_reg;
      long_wait_multiplier   <= next_long_wait_multiplier;
      led_pulse_count        <= next_led_pulse_count;
      o_reg_rdata            <= next_reg_rdata;
    end
  end

  // Sequencer state.
  spf_pkg::spf_state_t state, next_state;
  logic [23:0] tick;         // Cycles within one 2.72 ms step.
  logic [11:0] steps;        // Steps left in the current phase.
  logic [8:0]  phase;        // Cycles within one LED pulse period.
  logic [7:0]  pulses;       // LED pulses left in this cycle.
  logic [23:0] next_tick;
  logic [11:0] next_steps;
  logic [8:0]  next_phase;
  logic [7:0]  next_pulses;
  logic        next_led;
  logic        next_light_end;
  logic        next_prox_end;
  logic        any_enable;   // Either measurement function runs.
  logic [11:0] light_steps;  // Integration length in steps.
  logic [11:0] wait_steps;   // Wait length in steps.

  // Both settings count upward to 256, so the length is 256 minus value.
  always_comb begin
    any_enable  = i_light_enable | i_prox_enable;
    light_steps = 12'(`SPF_STEP_RANGE) - {4'h0, i_light_integration_setting};
    wait_steps  = 12'(`SPF_STEP_RANGE) - {4'h0, i_wait_period_setting};
    if (long_wait_multiplier) begin
      wait_steps = 12'(wait_steps * `SPF_LONG_WAIT_FACTOR);
    end
  end

  // Next sequencer values. The light phase runs whenever either function is
  // on, even with the light function off, because it spaces the proximity cycles.
  always_comb begin
    next_state     = state;
    next_tick      = tick;
    next_steps     = steps;
    next_phase     = phase;
    next_pulses    = pulses;
    next_led       = 1'b0;
    next_light_end = 1'b0;
    next_prox_end  = 1'b0;
    case (state)
      spf_pkg::SPF_IDLE: begin
        if (any_enable) begin
          next_state = spf_pkg::SPF_LIGHT;
          next_tick  = 24'h00_0000;
          next_steps = light_steps;
        end
      end
      spf_pkg::SPF_LIGHT: begin
        next_tick = tick + 24'h00_0001;
        if (!any_enable) begin
          next_state = spf_pkg::SPF_IDLE;
        end else if (tick >= TICK_LAST) begin
          next_tick = 24'h00_0000;
          if (steps <= 12'h001) begin
            next_light_end = 1'b1;
            if (i_prox_enable) begin
              next_state  = spf_pkg::SPF_PROX;
              next_phase  = 9'h000;
              next_pulses = led_pulse_count;
              // The first pulse starts on entry, so it is as long as the rest.
              next_led    = (led_pulse_count != 8'h00);
            end else if (i_wait_enable) begin
              next_state = spf_pkg::SPF_WAIT;
              next_steps = wait_steps;
            end else begin
              next_steps = light_steps;
            end
          end else begin
            next_steps = steps - 12'h001;
          end
        end
      end
      spf_pkg::SPF_PROX: begin
        next_phase = phase + 9'h001;
        next_led   = (pulses != 8'h00) && (next_phase < PULSE_HALF);
        if (!any_enable) begin
          next_state = spf_pkg::SPF_IDLE;
          next_led   = 1'b0;
        end else if (pulses == 8'h00 || phase >= PULSE_LAST) begin
          next_phase = 9'h000;
          if (pulses <= 8'h01) begin
            // Last pulse done: the proximity cycle ends here.
            next_pulses   = 8'h00;
            next_prox_end = 1'b1;
            next_led      = 1'b0;
            next_tick     = 24'h00_0000;
            if (i_wait_enable) begin
              next_state = spf_pkg::SPF_WAIT;
              next_steps = wait_steps;
            end else begin
              next_state = spf_pkg::SPF_LIGHT;
              next_steps = light_steps;
            end
          end else begin
            next_pulses = pulses - 8'h01;
            next_led    = 1'b1;
          end
        end
      end
      spf_pkg::SPF_WAIT: begin
        next_tick = tick + 24'h00_0001;
        if (!any_enable) begin
          next_state = spf_pkg::SPF_IDLE;
        end else if (tick >= TICK_LAST) begin
          next_tick = 24'h00_0000;
          if (steps <= 12'h001) begin
            next_state = spf_pkg::SPF_LIGHT;
            next_steps = light_steps;
          end else begin
            next_steps = steps - 12'h001;
          end
        end
      end
      default: begin
        next_state = spf_pkg::SPF_IDLE;
      end
    endcase
  end

  // Sequencer registers.
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state             <= spf_pkg::SPF_IDLE;
      tick              <= 24'h00_0000;
      steps             <= 12'h000;
      phase             <= 9'h000;
      pulses            <= 8'h00;
      o_led_pulse       <= 1'b0;
      o_light_cycle_end <= 1'b0;
      o_prox_cycle_end  <= 1'b0;
    end else begin
      state             <= next_state;
      tick              <= next_tick;
      steps             <= next_steps;
      phase             <= next_phase;
      pulses            <= next_pulses;
      o_led_pulse       <= next_led;
      o_light_cycle_end <= next_light_end;
      o_prox_cycle_end  <= next_prox_end;
    end
  end

  // Persistence state, one counter per channel, never shared.
  logic [3:0] prox_persist_count;   // Proximity persistence code.
  logic [3:0] light_persist_count;  // Light persistence code.
  logic [3:0] prox_run;             // Consecutive proximity misses.
  logic [5:0] light_run;            // Consecutive light misses.
  logic [3:0] next_prox_run;
  logic [5:0] next_light_run;
  logic       next_prox_pending;
  logic       next_light_pending;
  logic       prox_hit;
  logic       light_hit;
  logic       next_int;

  // Counters saturate at their top code, so a long miss run never wraps.
  always_comb begin
    prox_persist_count  = persistence_filter_reg[`SPF_PROX_INTERRUPT_PERSISTENCE_HI:
                                                 `SPF_PROX_INTERRUPT_PERSISTENCE_LO];
    light_persist_count = persistence_filter_reg[`SPF_LIGHT_INTERRUPT_PERSISTENCE_HI:
                                                 `SPF_LIGHT_INTERRUPT_PERSISTENCE_LO];
    next_prox_run  = prox_run;
    next_light_run = light_run;
    prox_hit       = 1'b0;
    light_hit      = 1'b0;
    if (i_prox_result.done) begin
      if (!out_of_range(i_prox_result)) begin
        next_prox_run = 4'h0;
      end else if (prox_run != 4'hf) begin
        next_prox_run = prox_run + 4'h1;
      end
      prox_hit = (prox_persist_count == 4'h0) ||
                 (out_of_range(i_prox_result) &&
                  next_prox_run >= prox_persist_count);
    end
    if (i_channel_zero_result.done) begin
      if (!out_of_range(i_channel_zero_result)) begin
        next_light_run = 6'h00;
      end else if (light_run != 6'h3f) begin
        next_light_run = light_run + 6'h01;
      end
      light_hit = (light_persist_count == 4'h0) ||
                  (out_of_range(i_channel_zero_result) &&
                   next_light_run >= light_required(light_persist_count));
    end
    // A clear and a new event in one cycle: the event wins.
    next_prox_pending  = o_prox_irq_pending;
    next_light_pending = o_light_irq_pending;
    if (i_sf_valid && (i_sf_code == `SPF_SF_CLR_PROX ||
                       i_sf_code == `SPF_SF_CLR_BOTH)) begin
      next_prox_pending = 1'b0;
    end
    if (i_sf_valid && (i_sf_code == `SPF_SF_CLR_LIGHT ||
                       i_sf_code == `SPF_SF_CLR_BOTH)) begin
      next_light_pending = 1'b0;
    end
    if (prox_hit) begin
      next_prox_pending = 1'b1;
    end
    if (light_hit) begin
      next_light_pending = 1'b1;
    end
    next_int = (next_prox_pending & i_prox_irq_mask) |
               (next_light_pending & i_light_irq_mask);
  end

  // Persistence and interrupt pin registers; the pin is open drain.
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      prox_run            <= 4'h0;
      light_run           <= 6'h00;
      o_prox_irq_pending  <= 1'b0;
      o_light_irq_pending <= 1'b0;
      o_int_out           <= 1'b0;
      o_int_oe_b          <= 1'b1;
    end else begin
      prox_run            <= next_prox_run;
      light_run           <= next_light_run;
      o_prox_irq_pending  <= next_prox_pending;
      o_light_irq_pending <= next_light_pending;
      o_int_out           <= 1'b0;
      o_int_oe_b          <= ~next_int;
    end
  end

endmodule

// ==== src/spf_params.svh ====
// Register offsets, field positions, reset values and timing figures.
`ifndef SPF_PARAMS_SVH
`define SPF_PARAMS_SVH

// Register offsets on the device register port.
`define SPF_OFS_PERSIST       5'h0c
`define SPF_OFS_WAIT_CFG      5'h0d
`define SPF_OFS_PULSE_CNT     5'h0e

// Field positions.
`define SPF_PROX_INTERRUPT_PERSISTENCE_HI      7
`define SPF_PROX_INTERRUPT_PERSISTENCE_LO      4
`define SPF_LIGHT_INTERRUPT_PERSISTENCE_HI     3
`define SPF_LIGHT_INTERRUPT_PERSISTENCE_LO     0
`define SPF_LONG_WAIT_BIT     1

// Reset values.
`define SPF_RST_PERSIST       8'h00
`define SPF_RST_LONG_WAIT     1'b0
`define SPF_RST_PULSE_CNT     8'h00

// Special-function clear codes.
`define SPF_SF_CLR_PROX       5'h05
`define SPF_SF_CLR_LIGHT      5'h06
`define SPF_SF_CLR_BOTH       5'h07

// Timing: clock period, time base step, LED pulse period, in ns.
`define SPF_CLK_PERIOD_NS     50
`define SPF_TIME_BASE_NS      2720000
`define SPF_PULSE_PERIOD_NS   16000
`define SPF_PULSE_CYCLES      (`SPF_PULSE_PERIOD_NS / `SPF_CLK_PERIOD_NS)
`define SPF_LONG_WAIT_FACTOR  12
`define SPF_STEP_RANGE        256

`endif

// ==== src/spf_pkg.sv ====
// Types shared by the persistence and pulse configuration block.
package spf_pkg;

  // Sequencer states, one-hot.
  typedef enum logic [3:0] {
    SPF_IDLE  = 4'b0001,
    SPF_LIGHT = 4'b0010,
    SPF_PROX  = 4'b0100,
    SPF_WAIT  = 4'b1000
  } spf_state_t;

  // One register access from the serial interface logic.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [4:0] addr;
    logic [7:0] wdata;
  } spf_reg_req_t;

  // A finished conversion with its threshold window.
  typedef struct packed {
    logic        done;
    logic [15:0] result;
    logic [15:0] low;
    logic [15:0] high;
  } spf_result_t;

endpackage

// ==== dv/spf_props.sv ====
// Checker of clears, persistence hits, pin, read-back and LED rate.
`timescale 1ns/1ps
`include "spf_params.svh"
module spf_props #(
  parameter int unsigned TIME_BASE_CYCLES = 4
) (
  // Clock and reset.
  input wire logic                  i_clock,
  input wire logic                  i_rst_b,
  // Host side.
  input wire spf_pkg::spf_reg_req_t i_reg_req,
  input wire logic                  i_sf_valid,
  input wire logic [4:0]            i_sf_code,
  input wire logic [7:0]            o_reg_rdata,
  input wire logic                  i_prox_enable,
  input wire logic                  i_prox_irq_mask,
  input wire logic                  i_light_irq_mask,
  // Results and device outputs.
  input wire spf_pkg::spf_result_t  i_channel_zero_result,
  input wire spf_pkg::spf_result_t  i_prox_result,
  input wire logic                  o_led_pulse,
  input wire logic                  o_prox_cycle_end,
  input wire logic                  o_prox_irq_pending,
  input wire logic                  o_light_irq_pending,
  input wire logic                  o_int_oe_b
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  logic [7:0]  interrupt_persistence;   // Copy of the persistence byte.
  logic        lw;     // Copy of the long-wait bit.
  logic [15:0] since;  // Cycles since the last LED rise.
  logic        seen;   // A rise came earlier in this proximity cycle.
  logic        led_d;  // LED level one cycle back.
  logic        rise;   // LED rising now.
  logic        hit_p;  // Proximity result that may set the flag.
  logic        hit_l;  // Light result that may set the flag.
  // Out of window means strictly below low or strictly above high.
  function automatic logic oor(spf_pkg::spf_result_t r);
    return r.result < r.low || r.result > r.high;
  endfunction
  assign rise  = o_led_pulse && !led_d;
  assign hit_p = i_prox_result.done && (interrupt_persistence[7:4] == 4'h0 || oor(i_prox_result));
  assign hit_l = i_channel_zero_result.done &&
    (interrupt_persistence[3:0] == 4'h0 || oor(i_channel_zero_result));
  // Shadows follow host writes, so the checker needs no read port.
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      interrupt_persistence  <= 8'h00;
      lw    <= 1'b0;
      since <= 16'h0000;
      seen  <= 1'b0;
      led_d <= 1'b0;
    end else begin
      if (i_reg_req.wr && i_reg_req.addr == `SPF_OFS_PERSIST) begin
        interrupt_persistence <= i_reg_req.wdata;
      end
      if (i_reg_req.wr && i_reg_req.addr == `SPF_OFS_WAIT_CFG) begin
        lw <= i_reg_req.wdata[`SPF_LONG_WAIT_BIT];
      end
      since <= rise ? 16'h0001 : since + 16'h0001;
      seen  <= (o_prox_cycle_end || !i_prox_enable) ? 1'b0 : (seen || rise);
      led_d <= o_led_pulse;
    end
  end
  // A clear drops its flag unless a result lands in the same cycle.
  sequence s_clr_p;
    i_sf_valid && !i_prox_result.done && (i_sf_code == `SPF_SF_CLR_PROX
      || i_sf_code == `SPF_SF_CLR_BOTH);
  endsequence
  sequence s_clr_l;
    i_sf_valid && !i_channel_zero_result.done && (i_sf_code ==
      `SPF_SF_CLR_LIGHT || i_sf_code == `SPF_SF_CLR_BOTH);
  endsequence
  property p_clr_prox; s_clr_p |=> !o_prox_irq_pending; endproperty
  a_clr_prox: assert property (p_clr_prox) else $error("prox clear lost");
  property p_clr_light; s_clr_l |=> !o_light_irq_pending; endproperty
  a_clr_light: assert property (p_clr_light) else $error("light clear lost");
  property p_prox_zero;
    i_prox_result.done && interrupt_persistence[7:4] == 4'h0 |=> o_prox_irq_pending;
  endproperty
  a_prox_zero: assert property (p_prox_zero) else $error("prox code 0");
  property p_light_zero;
    i_channel_zero_result.done && interrupt_persistence[3:0] == 4'h0 |=> o_light_irq_pending;
  endproperty
  a_light_zero: assert property (p_light_zero) else $error("light code 0");
  property p_prox_rise; $rose(o_prox_irq_pending) |-> $past(hit_p); endproperty
  a_prox_rise: assert property (p_prox_rise) else $error("prox set");
  property p_light_rise; $rose(o_light_irq_pending) |-> $past(hit_l); endproperty
  a_light_rise: assert property (p_light_rise) else $error("light set");
  property p_pin;
    $stable(i_prox_irq_mask) && $stable(i_light_irq_mask) |-> o_int_oe_b ==
      !(o_prox_irq_pending && i_prox_irq_mask ||
        o_light_irq_pending && i_light_irq_mask);
  endproperty
  a_pin: assert property (p_pin) else $error("interrupt pin");
  property p_rd_interrupt_persistence;
    i_reg_req.rd && !i_reg_req.wr && i_reg_req.addr == `SPF_OFS_PERSIST
      |=> o_reg_rdata == interrupt_persistence;
  endproperty
  a_rd_interrupt_persistence: assert property (p_rd_interrupt_persistence) else $error("persist read");
  property p_rd_cfg;
    i_reg_req.rd && !i_reg_req.wr && i_reg_req.addr == `SPF_OFS_WAIT_CFG
      |=> o_reg_rdata == {6'h00, lw, 1'b0};
  endproperty
  a_rd_cfg: assert property (p_rd_cfg) else $error("config read");
  property p_led_rate; rise && seen |-> since == `SPF_PULSE_CYCLES; endproperty
  a_led_rate: assert property (p_led_rate) else $error("pulse rate");
endmodule

bind spf_core spf_props #(.TIME_BASE_CYCLES(TIME_BASE_CYCLES)) u_props (
  .i_clock(i_clock), .i_rst_b(i_rst_b), .i_reg_req(i_reg_req),
  .i_sf_valid(i_sf_valid), .i_sf_code(i_sf_code),
  .o_reg_rdata(o_reg_rdata), .i_prox_enable(i_prox_enable),
  .i_prox_irq_mask(i_prox_irq_mask), .i_light_irq_mask(i_light_irq_mask),
  .i_channel_zero_result(i_channel_zero_result),
  .i_prox_result(i_prox_result), .o_led_pulse(o_led_pulse),
  .o_prox_cycle_end(o_prox_cycle_end),
  .o_prox_irq_pending(o_prox_irq_pending),
  .o_light_irq_pending(o_light_irq_pending), .o_int_oe_b(o_int_oe_b));

// ==== dv/spf_host.sv ====
// Host model: register port, clear commands and pulled-up interrupt line.
`timescale 1ns/1ps
`include "spf_params.svh"
module spf_host (
  // Clock.
  input  wire logic             i_clock,
  // Device answers.
  input  wire logic [7:0]       i_rdata,
  input  wire logic             i_int_out,
  input  wire logic             i_int_oe_b,
  // Requests to the device.
  output spf_pkg::spf_reg_req_t o_req,
  output logic                  o_sf_valid,
  output logic [4:0]            o_sf_code,
  output logic                  o_int_line
);
  // The line has a pull-up, so it rests high whenever released.
  assign o_int_line = i_int_oe_b ? 1'b1 : i_int_out;
  initial begin
    o_req = '0;
    o_sf_valid = 1'b0;
    o_sf_code = 5'h00;
  end
  // One write; reserved bits go as zero and pulses stay at 32 or fewer.
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = (a == `SPF_OFS_WAIT_CFG) ? (d & 8'h02) : d;
    v = (a == `SPF_OFS_PULSE_CNT && v > 8'h20) ? 8'h20 : v;
    @(posedge i_clock);
    o_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge i_clock);
    o_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~v};
    #1;
  endtask
  // One read; data is taken one cycle after the read edge.
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge i_clock);
    o_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge i_clock);
    o_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
    #1;
    d = i_rdata;
  endtask
  // One clear command; the code is scrambled once the strobe drops.
  task automatic sf(input logic [4:0] c);
    @(posedge i_clock);
    o_sf_valid <= 1'b1;
    o_sf_code <= c;
    @(posedge i_clock);
    o_sf_valid <= 1'b0;
    o_sf_code <= ~c;
    #1;
  endtask
endmodule

// ==== dv/testbench.sv ====
// Self-checking bench of the persistence and LED pulse block.
`timescale 1ns/1ps
`include "spf_params.svh"
module testbench;
  localparam int TB = 4;  // Short time base keeps the run brief.
  logic                  i_clock, i_rst_b, sfv, len, pen, wen, pmask, lmask;
  spf_pkg::spf_reg_req_t req;
  logic [4:0]            sfc;
  logic [7:0]            rdata, integ, wper;
  spf_pkg::spf_result_t  cz, pr;
  logic                  led, lend, pend, ppend, lpend, int_o, oe_b, int_line;
  int                    error_cnt = 0, comparisons = 0, lr = 0, lc = 0, cyc = 0;
  int                    pe_q[$], lr_q[$], lc_q[$];
  logic                  led_d = 1'b0;
  spf_core #(.TIME_BASE_CYCLES(TB)) dut (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_reg_req(req),
    .i_sf_valid(sfv), .i_sf_code(sfc), .o_reg_rdata(rdata),
    .i_light_enable(len), .i_prox_enable(pen), .i_wait_enable(wen),
    .i_prox_irq_mask(pmask), .i_light_irq_mask(lmask),
    .i_light_integration_setting(integ), .i_wait_period_setting(wper),
    .i_channel_zero_result(cz), .i_prox_result(pr), .o_led_pulse(led),
    .o_light_cycle_end(lend), .o_prox_cycle_end(pend),
    .o_prox_irq_pending(ppend), .o_light_irq_pending(lpend),
    .o_int_out(int_o), .o_int_oe_b(oe_b));
  spf_host host (
    .i_clock(i_clock), .i_rdata(rdata), .i_int_out(int_o),
    .i_int_oe_b(oe_b), .o_req(req), .o_sf_valid(sfv), .o_sf_code(sfc),
    .o_int_line(int_line));
  always #25 i_clock = ~i_clock;
  // Sampled on the falling edge, away from the registered outputs.
  always @(negedge i_clock) begin
    cyc++;
    if (led && !led_d) lr++;
    if (lend) lc++;
    led_d = led;
    if (pend) begin
      pe_q.push_back(cyc);
      lr_q.push_back(lr);
      lc_q.push_back(lc);
    end
  end
  task automatic finish_test();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Every compare task ends here, so counting stays in one place.
  task automatic note(input bit bad, input string m);
    comparisons++;
    if (bad) begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e, input string m);
    note(g !== e, m);
  endtask
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e,
                          input string m);
    note(g !== e, m);
  endtask
  task automatic chk_int(input int g, input int e, input string m);
    note(g != e, m);
  endtask
  // One result of one channel against the window 0x0064..0x00c8.
  task automatic res(input bit px, input logic [15:0] v);
    spf_pkg::spf_result_t r;
    r = '{done: 1'b1, result: v, low: 16'h0064, high: 16'h00c8};
    @(posedge i_clock);
    if (px) pr <= r;
    else cz <= r;
    @(posedge i_clock);
    if (px) pr <= ~r;
    else cz <= ~r;
    #1;
  endtask
  // A broken run must restart the count; the last hit of a run sets.
  task automatic run_code(input bit px, input logic [3:0] c);
    int n;
    n = (c == 0) ? 1 : (px || c < 4) ? c : 5 * (c - 3);
    host.wr(`SPF_OFS_PERSIST, px ? {c, 4'hf} : {4'hf, c});
    host.sf(`SPF_SF_CLR_BOTH);
    if (c == 0) res(px, 16'h0096);
    else begin
      res(px, 16'h0064);
      repeat (n - 1) res(px, 16'h0032);
      res(px, 16'h0064);
      repeat (n - 1) res(px, 16'h012c);
      chk_bit(px ? ppend : lpend, 1'b0, "early flag");
      res(px, 16'h00c9);
    end
    chk_bit(px ? ppend : lpend, 1'b1, "flag missing");
    chk_bit(px ? lpend : ppend, 1'b0, "other flag");
  endtask
  // Cycles and pulses of one whole proximity period, from fresh events.
  task automatic gap(output int g, output int n);
    pe_q.delete();
    lr_q.delete();
    lc_q.delete();
    for (int k = 0; k < 8000 && pe_q.size() < 3; k++) @(posedge i_clock);
    if (pe_q.size() < 3) begin
      note(1'b1, "sequencer timeout");
      finish_test();
    end else begin
      g = pe_q[2] - pe_q[1];
      n = lr_q[2] - lr_q[1];
    end
  endtask
  initial begin
    logic [7:0] d;
    int g0, g1, n;
    i_clock = 1'b0;
    i_rst_b = 1'b0;
    {len, pen, wen, pmask, lmask} = 5'h00;
    integ = 8'hfe;
    wper = 8'hfe;
    cz = '0;
    pr = '0;
    repeat (16) @(posedge i_clock);
    i_rst_b <= 1'b1;
    for (int a = 12; a < 16; a++) begin
      host.rd(a[4:0], d);
      chk_byte(d, 8'h00, "reset or unmapped read");
    end
    host.wr(`SPF_OFS_PERSIST, 8'ha5);
    host.rd(`SPF_OFS_PERSIST, d);
    chk_byte(d, 8'ha5, "persist read");
    host.wr(`SPF_OFS_WAIT_CFG, 8'h02);
    host.rd(`SPF_OFS_WAIT_CFG, d);
    chk_byte(d, 8'h02, "config read");
    host.wr(`SPF_OFS_PULSE_CNT, 8'h20);
    host.rd(`SPF_OFS_PULSE_CNT, d);
    chk_byte(d, 8'h20, "pulse read");
    @(posedge i_clock);
    i_rst_b <= 1'b0;
    @(posedge i_clock);
    i_rst_b <= 1'b1;
    host.rd(`SPF_OFS_PULSE_CNT, d);
    chk_byte(d, 8'h00, "pulse after reset");
    for (int c = 0; c < 16; c++) run_code(1'b0, c[3:0]);
    for (int c = 0; c < 16; c++) run_code(1'b1, c[3:0]);
    pmask <= 1'b1;
    host.wr(`SPF_OFS_PERSIST, 8'h00);
    res(1'b1, 16'h0096);
    res(1'b0, 16'h0096);
    chk_bit(int_line, 1'b0, "pin not pulled");
    host.sf(`SPF_SF_CLR_PROX);
    chk_bit(ppend, 1'b0, "prox clear");
    chk_bit(lpend, 1'b1, "light kept");
    chk_bit(int_line, 1'b1, "pin with masked light");
    @(posedge i_clock);
    lmask <= 1'b1;
    @(posedge i_clock);
    #1;
    chk_bit(int_line, 1'b0, "pin with light");
    host.sf(`SPF_SF_CLR_LIGHT);
    chk_bit(lpend, 1'b0, "light clear");
    res(1'b1, 16'h0096);
    host.sf(`SPF_SF_CLR_BOTH);
    chk_bit(ppend, 1'b0, "both clear");
    host.wr(`SPF_OFS_PULSE_CNT, 8'h03);
    host.wr(`SPF_OFS_WAIT_CFG, 8'h00);
    @(posedge i_clock);
    {len, pen, wen} <= 3'h7;
    gap(g0, n);
    chk_int(n, 3, "pulses per cycle");
    chk_int(lc_q[2] - lc_q[1], 1, "light per prox cycle");
    host.wr(`SPF_OFS_WAIT_CFG, 8'h02);
    gap(g1, n);
    chk_int(g1 - g0, 11 * 2 * TB, "long wait stretch");
    @(posedge i_clock);
    {len, wen} <= 2'h0;
    gap(g0, n);
    @(posedge i_clock);
    integ <= 8'hfc;
    gap(g1, n);
    chk_int(g1 - g0, 2 * TB, "interval without light");
    finish_test();
  end
endmodule
